// ---- core/secp_eeprom_cfg.sv ----
// Purpose: indirect register window with serial EEPROM programming
// Assumes: host strobes are single-cycle and synchronous to mclk
// Notes:   commands while the serial interface is busy are dropped
// Summary of operation
// - EEPROM holds 64 words of 16 bits
// - configuration read from EEPROM after every reset
// - host reprograms EEPROM through window registers only
// - seven serial operations started by command writes
// - word zero is presence flag and byte count
// - station address in three consecutive words
// - checksum makes byte sum of image zero
// - data port reaches pointed register, optional increment
// - I/O base address read from image, default 0x0300
`timescale 1ns/1ns
`default_nettype none
module secp_eeprom_cfg
  import secp_pkg::*;
#(
  parameter int TMO_CYC = WR_TMO_CYC
)(
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        ptr_wr,
  input  wire logic [15:0] ptr_wdata,
  output logic [15:0]      ptr_rdata,
  input  wire logic        data_wr,
  input  wire logic        data_rd,
  input  wire logic [15:0] data_wdata,
  output logic [15:0]      data_rdata,
  output logic             cfg_done,
  output logic             cfg_present,
  output logic             cfg_csum_ok,
  output logic [15:0]      cfg_iface,
  output logic [15:0]      io_base,
  output logic [15:0]      cfg_irq,
  output logic [15:0]      cfg_dma,
  output logic [47:0]      station_addr,
  output logic             ee_cs,
  output logic             ee_sk,
  output logic             ee_di,
  input  wire logic        ee_do
);

  logic [14:0]          indirect_reg_pointer;
  logic                 autoinc_r;
  logic [15:0]          cmd_r;
  logic [15:0]          eedata_r;
  logic                 host_rd_r;
  secp_bt_t             bt_r;
  logic [5:0]           widx_r;
  logic [5:0]           wlast_r;
  logic [7:0]           sum_r;
  logic [7:0]           wsum;
  logic                 si_busy;
  logic                 host_start;
  logic                 boot_start;
  logic                 eng_busy;
  logic                 eng_done;
  logic [15:0]          eng_rdata;
  logic [1:0]           eng_op;
  logic [EE_ADDR_W-1:0] eng_addr;
  logic [15:0]          stat_w;

  // host is locked out until the boot load has finished
  assign si_busy    = eng_busy || (bt_r != BT_DONE);
  assign host_start = data_wr && !si_busy &&
                      (indirect_reg_pointer == REG_EE_CMD);
  assign boot_start = (bt_r == BT_ISSUE) && !eng_busy;
  assign eng_op     = boot_start ? OP_READ :
                      data_wdata[CMD_OP_LSB+1:CMD_OP_LSB];
  assign eng_addr   = boot_start ? widx_r :
                      data_wdata[EE_ADDR_W-1:0];
  assign wsum       = sum_r + eng_rdata[15:8] + eng_rdata[7:0];
  assign ptr_rdata  = {autoinc_r, indirect_reg_pointer};
  assign cfg_done   = (bt_r == BT_DONE);

  secp_uwire #(
    .TMO_CYC (TMO_CYC)
  ) u_wire (
    .mclk  (mclk),
    .rstn  (rstn),
    .start (boot_start || host_start),
    .op    (eng_op),
    .addr  (eng_addr),
    .wdata (eedata_r),
    .busy  (eng_busy),
    .done  (eng_done),
    .rdata (eng_rdata),
    .ee_cs (ee_cs),
    .ee_sk (ee_sk),
    .ee_di (ee_di),
    .ee_do (ee_do)
  );

  // pointer and its optional auto-increment by one register
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      indirect_reg_pointer <= '0;
      autoinc_r            <= 1'b0;
    end
    else if (ptr_wr)
    begin
      indirect_reg_pointer <= ptr_wdata[14:0];
      autoinc_r            <= ptr_wdata[PTR_AINC_BIT];
    end
    else if (autoinc_r && (data_wr || data_rd))
      indirect_reg_pointer <= indirect_reg_pointer + PTR_STEP;
  end

  // command and data registers of the serial interface
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      cmd_r     <= '0;
      eedata_r  <= '0;
      host_rd_r <= 1'b0;
    end
    else
    begin
      if (host_start)
        cmd_r <= data_wdata;
      if (host_start)
        host_rd_r <= (eng_op == OP_READ);
      else if (eng_done)
        host_rd_r <= 1'b0;
      // read result wins over a stray host write in the same cycle
      if (eng_done && host_rd_r)
        eedata_r <= eng_rdata;
      else if (data_wr && indirect_reg_pointer == REG_EE_DATA)
        eedata_r <= data_wdata;
    end
  end

  // status word seen at the status pointer
  always_comb
  begin
    stat_w               = 16'h0000;
    stat_w[SI_BUSY_BIT]  = si_busy;
    stat_w[EE_PRES_BIT]  = cfg_present;
    stat_w[CSUM_OK_BIT]  = cfg_csum_ok;
    stat_w[CFG_DONE_BIT] = cfg_done;
  end

  // data port read, registered one cycle after the strobe
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      data_rdata <= '0;
    else if (data_rd)
    begin
      unique case (indirect_reg_pointer)
        REG_EE_CMD:  data_rdata <= cmd_r;
        REG_EE_DATA: data_rdata <= eedata_r;
        REG_SI_STAT: data_rdata <= stat_w;
        default:     data_rdata <= 16'h0000;
      endcase
    end
  end

  // boot loader walks the image from word zero
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      bt_r        <= BT_ISSUE;
      widx_r      <= '0;
      wlast_r     <= '0;
      sum_r       <= '0;
      cfg_present <= 1'b0;
      cfg_csum_ok <= 1'b0;
    end
    else
    begin
      unique case (bt_r)
        BT_ISSUE:
          if (!eng_busy)
            bt_r <= BT_WAIT;
        BT_WAIT:
          if (eng_done)
          begin
            sum_r <= wsum;
            if (widx_r == 6'h00)
            begin
              // low byte counts bytes that follow word zero
              cfg_present <= (eng_rdata[15:8] == CFG_PRES_TAG);
              wlast_r     <= eng_rdata[6:1];
              if (eng_rdata[15:8] != CFG_PRES_TAG ||
                  eng_rdata[6:1] == 6'h00)
              begin
                cfg_csum_ok <= (eng_rdata[15:8] == CFG_PRES_TAG) &&
                               (wsum == 8'h00);
                bt_r        <= BT_DONE;
              end
              else
              begin
                widx_r <= 6'h01;
                bt_r   <= BT_ISSUE;
              end
            end
            else if (widx_r == wlast_r)
            begin
              cfg_csum_ok <= (wsum == 8'h00);
              bt_r        <= BT_DONE;
            end
            else
            begin
              widx_r <= widx_r + 6'h01;
              bt_r   <= BT_ISSUE;
            end
          end
        BT_DONE:
          bt_r <= BT_DONE;
      endcase
    end
  end

  // loaded fields; an absent part leaves the board defaults
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      cfg_iface    <= '0;
      io_base      <= IO_BASE_DEF;
      cfg_irq      <= '0;
      cfg_dma      <= '0;
      station_addr <= '0;
    end
    else if (bt_r == BT_WAIT && eng_done && widx_r != 6'h00)
    begin
      unique case (widx_r)
        IMG_IFACE:  cfg_iface          <= eng_rdata;
        IMG_IOBASE: io_base            <= eng_rdata;
        IMG_IRQ:    cfg_irq            <= eng_rdata;
        IMG_DMA:    cfg_dma            <= eng_rdata;
        IMG_STA0:   station_addr[15:0] <= eng_rdata;
        IMG_STA1:   station_addr[31:16] <= eng_rdata;
        IMG_STA2:   station_addr[47:32] <= eng_rdata;
        default:    cfg_iface          <= cfg_iface;
      endcase
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  AST_STAT_BUSY: assert property (
    (data_rd && indirect_reg_pointer == REG_SI_STAT) |=>
      (data_rdata[SI_BUSY_BIT] == $past(si_busy)))
    else $error("status read lost the busy flag");

  AST_PTR_INC: assert property (
    (autoinc_r && data_wr && !ptr_wr) |=>
      (indirect_reg_pointer == $past(indirect_reg_pointer) + PTR_STEP))
    else $error("pointer did not advance");

  AST_PTR_HOLD: assert property (
    (!autoinc_r && !ptr_wr) |=> $stable(indirect_reg_pointer))
    else $error("pointer moved without auto-increment");

  AST_CMD_START: assert property (
    host_start |=> (eng_busy && cmd_r == $past(data_wdata)))
    else $error("accepted command did not start");

  AST_BUSY_DROP: assert property (
    (data_wr && si_busy) |=> $stable(cmd_r))
    else $error("command taken while busy");

  AST_BOOT_READ: assert property (
    boot_start |=> (eng_busy && bt_r == BT_WAIT))
    else $error("boot read not issued");

  AST_ABSENT_BASE: assert property (
    ($rose(cfg_done) && !cfg_present) |-> (io_base == IO_BASE_DEF))
    else $error("default base lost without part");

endmodule : secp_eeprom_cfg
`default_nettype wire

// ---- core/secp_pkg.sv ----
// Purpose: shared constants and types for the serial config programmer
// Assumes: 125 MHz mclk, three-wire serial EEPROM of 64 x 16 bits
// Notes:   register window offsets are pointer values, not bus addresses
package secp_pkg;

  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int SK_HALF_NS    = 1000;
  localparam int SK_HALF_CYC   =
    (SK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_TMO_NS     = 10000000;
  localparam int WR_TMO_CYC    = WR_TMO_NS / CLK_PERIOD_NS;
  localparam int HCNT_W        = 7;
  localparam int TMO_W         = 21;

  // serial frame: start bit, 2 opcode bits, 6 address bits, 16 data bits
  localparam int          EE_ADDR_W  = 6;
  localparam logic [4:0]  HDR_BITS   = 5'd9;
  localparam logic [4:0]  FULL_BITS  = 5'd25;
  localparam logic [4:0]  RD_FIRST   = 5'd9;

  // indirect register window
  localparam logic [14:0] REG_EE_CMD   = 15'h0040;
  localparam logic [14:0] REG_EE_DATA  = 15'h0042;
  localparam logic [14:0] REG_SI_STAT  = 15'h0136;
  localparam logic [14:0] PTR_STEP     = 15'h0002;
  localparam int          PTR_AINC_BIT = 15;
  localparam int          SI_BUSY_BIT  = 8;
  localparam int          EE_PRES_BIT  = 9;
  localparam int          CSUM_OK_BIT  = 10;
  localparam int          CFG_DONE_BIT = 11;

  // command word fields and opcodes
  localparam int         CMD_OP_LSB = 8;
  localparam logic [1:0] OP_EXT     = 2'h0;
  localparam logic [1:0] OP_WRITE   = 2'h1;
  localparam logic [1:0] OP_READ    = 2'h2;
  localparam logic [1:0] OP_ERASE   = 2'h3;
  localparam logic [1:0] EXT_EWDS   = 2'h0;
  localparam logic [1:0] EXT_WRAL   = 2'h1;
  localparam logic [1:0] EXT_ERAL   = 2'h2;
  localparam logic [1:0] EXT_EWEN   = 2'h3;

  // configuration image layout and defaults
  localparam logic [7:0]  CFG_PRES_TAG = 8'ha1;
  localparam logic [15:0] DEF_CFG_WORD = 16'ha112;
  localparam logic [15:0] DEF_CSUM     = 16'h8100;
  localparam logic [15:0] END_MARK     = 16'hffff;
  localparam logic [15:0] IO_BASE_DEF  = 16'h0300;
  localparam logic [5:0]  IMG_IFACE    = 6'h01;
  localparam logic [5:0]  IMG_IOBASE   = 6'h02;
  localparam logic [5:0]  IMG_IRQ      = 6'h03;
  localparam logic [5:0]  IMG_DMA      = 6'h04;
  localparam logic [5:0]  IMG_STA0     = 6'h06;
  localparam logic [5:0]  IMG_STA1     = 6'h07;
  localparam logic [5:0]  IMG_STA2     = 6'h08;

  typedef enum logic [4:0] {
    SE_IDLE  = 5'b00001,
    SE_SHIFT = 5'b00010,
    SE_GAP   = 5'b00100,
    SE_POLL  = 5'b01000,
    SE_DONE  = 5'b10000
  } secp_se_t;

  typedef enum logic [2:0] {
    BT_ISSUE = 3'b001,
    BT_WAIT  = 3'b010,
    BT_DONE  = 3'b100
  } secp_bt_t;

endpackage : secp_pkg

// ---- core/secp_uwire.sv ----
// Purpose: one serial EEPROM operation per start pulse
// Assumes: ee_do synchronous to mclk; caller holds eedata stable
// Notes:   write/erase ops poll the ready level before finishing
`timescale 1ns/1ns
`default_nettype none
module secp_uwire
  import secp_pkg::*;
#(
  parameter int TMO_CYC = WR_TMO_CYC
)(
  input  wire logic                 mclk,
  input  wire logic                 rstn,
  input  wire logic                 start,
  input  wire logic [1:0]           op,
  input  wire logic [EE_ADDR_W-1:0] addr,
  input  wire logic [15:0]          wdata,
  output logic                      busy,
  output logic                      done,
  output logic [15:0]               rdata,
  output logic                      ee_cs,
  output logic                      ee_sk,
  output logic                      ee_di,
  input  wire logic                 ee_do
);

  secp_se_t          st_r;
  logic [HCNT_W-1:0] hcnt_r;
  logic [TMO_W-1:0]  tmo_r;
  logic [24:0]       sh_r;
  logic [4:0]        bcnt_r;
  logic [4:0]        nbits_r;
  logic              poll_r;
  logic              rd_r;
  logic              tick;
  logic              ext_wr;
  logic              ext_er;

  // extended ops hide their sub-op in the top address bits
  assign ext_wr = (op == OP_EXT) && (addr[5:4] == EXT_WRAL);
  assign ext_er = (op == OP_EXT) && (addr[5:4] == EXT_ERAL);
  assign tick   = (hcnt_r == HCNT_W'(SK_HALF_CYC - 1));
  assign busy   = (st_r != SE_IDLE);
  assign done   = (st_r == SE_DONE);

  // half-period timer, held at zero outside shifting and gap
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      hcnt_r <= '0;
    else if ((st_r != SE_SHIFT && st_r != SE_GAP) || tick)
      hcnt_r <= '0;
    else
      hcnt_r <= hcnt_r + 1'b1;
  end

  // frame sequencer
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r    <= SE_IDLE;
      ee_cs   <= 1'b0;
      ee_sk   <= 1'b0;
      ee_di   <= 1'b0;
      sh_r    <= '0;
      bcnt_r  <= '0;
      nbits_r <= '0;
      poll_r  <= 1'b0;
      rd_r    <= 1'b0;
      rdata   <= '0;
      tmo_r   <= '0;
    end
    else
    begin
      unique case (st_r)
        SE_IDLE:
          if (start)
          begin
            // 6-bit word address covers all 64 words
            sh_r    <= {1'b1, op, addr,
                        (op == OP_WRITE || ext_wr) ? wdata : 16'h0000};
            ee_di   <= 1'b1;
            ee_cs   <= 1'b1;
            bcnt_r  <= '0;
            nbits_r <= (op == OP_WRITE || op == OP_READ || ext_wr) ?
                       FULL_BITS : HDR_BITS;
            poll_r  <= (op == OP_WRITE) || (op == OP_ERASE) ||
                       ext_wr || ext_er;
            rd_r    <= (op == OP_READ);
            st_r    <= SE_SHIFT;
          end
        SE_SHIFT:
          if (tick && !ee_sk)
            ee_sk <= 1'b1;
          else if (tick)
          begin
            ee_sk  <= 1'b0;
            bcnt_r <= bcnt_r + 1'b1;
            sh_r   <= {sh_r[23:0], 1'b0};
            ee_di  <= sh_r[23];
            // data follows the dummy zero after the address
            if (rd_r && bcnt_r >= RD_FIRST)
              rdata <= {rdata[14:0], ee_do};
            if (bcnt_r == nbits_r - 5'd1)
            begin
              ee_cs <= 1'b0;
              ee_di <= 1'b0;
              st_r  <= poll_r ? SE_GAP : SE_DONE;
            end
          end
        SE_GAP:
          if (tick)
          begin
            ee_cs <= 1'b1;
            tmo_r <= '0;
            st_r  <= SE_POLL;
          end
        SE_POLL:
        begin
          tmo_r <= tmo_r + 1'b1;
          // the first poll cycle still sees the released line, skip it;
          // a dead part must not hang the window forever
          if ((ee_do && tmo_r != '0) || tmo_r == TMO_W'(TMO_CYC - 1))
          begin
            ee_cs <= 1'b0;
            st_r  <= SE_DONE;
          end
        end
        SE_DONE:
          st_r <= SE_IDLE;
      endcase
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  localparam int SK_HI = SK_HALF_CYC;

  sequence s_poll_rdy;
    (st_r == SE_POLL) && (tmo_r != '0) && ee_do;
  endsequence

  AST_IDLE_QUIET: assert property (
    (st_r == SE_IDLE) |-> (!ee_cs && !ee_sk))
    else $error("serial pins active while idle");

  AST_SK_HIGH: assert property (
    $rose(ee_sk) |-> ##[SK_HI:SK_HI] $fell(ee_sk))
    else $error("clock high phase has wrong length");

  AST_POLL_END: assert property (
    s_poll_rdy |=> done ##1 !busy)
    else $error("ready seen but operation not finished");

  AST_START_FRAME: assert property (
    (start && !busy) |=> (ee_cs && ee_di && busy))
    else $error("start bit not driven on start");

endmodule : secp_uwire
`default_nettype wire

// ---- sim/secp_ee_model.sv ----
// Purpose: behavioural three-wire serial EEPROM, 64 x 16 bits
// Assumes: frames sampled on mclk; image handed in by parameter
// Notes:   released data line toggles so a stale bit never passes
`timescale 1ns/1ns
`default_nettype none
module secp_ee_model
#(
  parameter logic [15:0] IMG [10] = '{default: 16'hffff}
)(
  input  wire logic mclk,
  input  wire logic slow,
  input  wire logic ee_cs,
  input  wire logic ee_sk,
  input  wire logic ee_di,
  output logic      ee_do
);
  logic [15:0] mem [64];
  logic [24:0] sh     = '0;
  logic [8:0]  hdr    = '0;
  logic        cs_q   = 1'b0;
  logic        sk_q   = 1'b0;
  logic        en     = 1'b0;
  logic        tog    = 1'b0;
  logic        dbit   = 1'b0;
  logic        bsy_cs = 1'b0;
  int          n      = 0;
  int          bcnt   = 0;
  int          early  = 0;

  // image preload, end marker after the checksum word
  initial
  begin
    foreach (mem[i]) mem[i] = 16'hffff;
    foreach (IMG[i]) mem[i] = IMG[i];
  end

  // blocking state, ee_do updated late so the design sees a settled bit
  always @(posedge mclk)
  begin
    tog = ~tog;
    if (bcnt > 0) bcnt = bcnt - 1;
    // a frame opened while still programming is counted at its end
    if (ee_cs && !cs_q)
    begin
      n      = 0;
      hdr    = '0;
      bsy_cs = (bcnt > 0);
    end
    if (ee_cs && ee_sk && !sk_q)
    begin
      sh = {sh[23:0], ee_di};
      n  = n + 1;
      if (n == 9) hdr = sh[8:0];
      if (n >= 10 && n <= 25) dbit = mem[hdr[5:0]][25-n];
    end
    // seven operations, programming ones only while enabled
    if (!ee_cs && cs_q)
    begin
      if (n > 0 && bsy_cs) early = early + 1;
      if (n == 9 && hdr[7:4] == 4'h3) en = 1'b1;
      if (n == 9 && hdr[7:4] == 4'h0) en = 1'b0;
      if (en && n == 9 && hdr[7:4] == 4'h2)
        foreach (mem[i]) mem[i] = 16'hffff;
      if (en && n == 9 && hdr[7:6] == 2'h3) mem[hdr[5:0]] = 16'hffff;
      if (en && n == 25 && hdr[7:4] == 4'h1)
        foreach (mem[i]) mem[i] = sh[15:0];
      if (en && n == 25 && hdr[7:6] == 2'h1) mem[hdr[5:0]] = sh[15:0];
      if (en && hdr[7:6] != 2'h2 && hdr[7:4] != 4'h0 && hdr[7:4] != 4'h3)
        bcnt = slow ? 160 : 20;
    end
    cs_q = ee_cs;
    sk_q = ee_sk;
    ee_do <= ee_cs ? ((hdr[7:6] == 2'h2 && n >= 10) ? dbit : (bcnt == 0))
                   : tog;
  end
endmodule : secp_ee_model
`default_nettype wire

// ---- sim/secp_eeprom_cfg_tb.sv ----
// Purpose: self-checking bench for the serial config programmer
// Assumes: host window driven at falling mclk, short write timeout
// Notes:   boot of the full image dominates the run time
`timescale 1ns/1ns
`default_nettype none
module secp_eeprom_cfg_tb
  import secp_pkg::*;
();
  localparam logic [15:0] IMG [10] = '{16'ha112, 16'h2020, 16'h0300,
    16'h0000, 16'h0000, 16'h2158, 16'h0010, 16'h0000, 16'h0000, 16'h8100};
  logic        mclk, rstn, ptr_wr, data_wr, data_rd, slow;
  logic [15:0] ptr_wdata, data_wdata, ptr_rdata, data_rdata, w, v;
  logic [15:0] cfg_iface, io_base, cfg_irq, cfg_dma;
  logic        cfg_done, cfg_present, cfg_csum_ok, ee_cs, ee_sk, ee_di;
  logic        ee_do;
  logic [47:0] station_addr;
  logic [5:0]  a, d, e;
  int          num_errors, samples_checked, cycles, seed;

  secp_eeprom_cfg #(.TMO_CYC(50)) u_dut (.mclk(mclk), .rstn(rstn),
    .ptr_wr(ptr_wr), .ptr_wdata(ptr_wdata), .ptr_rdata(ptr_rdata),
    .data_wr(data_wr), .data_rd(data_rd), .data_wdata(data_wdata),
    .data_rdata(data_rdata), .cfg_done(cfg_done),
    .cfg_present(cfg_present), .cfg_csum_ok(cfg_csum_ok),
    .cfg_iface(cfg_iface), .io_base(io_base), .cfg_irq(cfg_irq),
    .cfg_dma(cfg_dma), .station_addr(station_addr), .ee_cs(ee_cs),
    .ee_sk(ee_sk), .ee_di(ee_di), .ee_do(ee_do));
  secp_ee_model #(.IMG(IMG)) u_ee (.mclk(mclk), .slow(slow), .ee_cs(ee_cs),
    .ee_sk(ee_sk), .ee_di(ee_di), .ee_do(ee_do));

  always #4 mclk = ~mclk;

  // hang guard, only some 13000 cycles above the expected run
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 110000)
    begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // byte sum of the image, zero when the checksum word is right
  function automatic logic csum_zero();
    logic [7:0] s;
    s = 8'h00;
    foreach (IMG[i]) s = s + IMG[i][15:8] + IMG[i][7:0];
    return s == 8'h00;
  endfunction : csum_zero

  function automatic logic [15:0] cw(logic [1:0] op, logic [5:0] ad);
    return {6'h00, op, 2'b00, ad};
  endfunction : cw

  // k: 0 pointer write, 1 data write, 2 data read; gap cycle after strobe
  task automatic port(input int k, input logic [15:0] val);
    ptr_wdata  = val;
    data_wdata = val;
    ptr_wr     = (k == 0);
    data_wr    = (k == 1);
    data_rd    = (k == 2);
    @(negedge mclk);
    {ptr_wr, data_wr, data_rd} = 3'b000;
    @(negedge mclk);
  endtask : port

  task automatic wait_idle();
    port(0, {1'b0, REG_SI_STAT});
    for (int i = 0; i < 5000; i++)
    begin
      port(2, 16'h0000);
      if (data_rdata[SI_BUSY_BIT] === 1'b0) break;
    end
    check(data_rdata[SI_BUSY_BIT], 1'b0);
  endtask : wait_idle

  // poll, load, then command, as for every stored word
  task automatic issue(input logic [15:0] c, input logic [15:0] val);
    wait_idle();
    port(0, {1'b0, REG_EE_DATA});
    port(1, val);
    port(0, {1'b0, REG_EE_CMD});
    port(1, c);
  endtask : issue

  task automatic boot();
    rstn = 1'b0;
    repeat (12) @(negedge mclk);
    check(io_base, IO_BASE_DEF);
    check(cfg_done, 1'b0);
    rstn = 1'b1;
    port(0, {1'b0, REG_SI_STAT});
    port(2, 16'h0000);
    check(data_rdata[11:8], 4'h1);
    for (int i = 0; i < 70000 && cfg_done !== 1'b1; i++) @(negedge mclk);
    check(cfg_done, 1'b1);
  endtask : boot

  initial
  begin
    {mclk, rstn, ptr_wr, data_wr, data_rd, slow} = '0;
    {ptr_wdata, data_wdata} = '0;
    {num_errors, samples_checked, cycles} = '0;
    seed = 32'h8f046811;
    w = 16'($random(seed));
    v = {~CFG_PRES_TAG, 8'($random(seed))};
    a = 6'h10 | 6'($random(seed) & 15);
    d = a + 6'h20;
    e = 6'h01 + 6'($random(seed) & 7);
    @(negedge mclk);
    boot();
    check(cfg_present, IMG[0][15:8] == CFG_PRES_TAG);
    check(cfg_csum_ok, csum_zero());
    check({cfg_iface, io_base, cfg_irq, cfg_dma},
          {IMG[1], IMG[2], IMG[3], IMG[4]});
    check(station_addr, {IMG[8], IMG[7], IMG[6]});
    port(0, {1'b0, REG_SI_STAT});
    port(2, 16'h0000);
    check(data_rdata[11:8], {1'b1, csum_zero(), 2'b10});
    // pointer auto-increment and unmapped slot
    port(0, {1'b1, REG_EE_DATA});
    check(ptr_rdata, {1'b1, REG_EE_DATA});
    port(1, w);
    check(ptr_rdata, {1'b1, REG_EE_DATA + PTR_STEP});
    port(0, {1'b0, REG_EE_DATA});
    port(2, 16'h0000);
    check(data_rdata, w);
    port(0, {1'b0, 15'h0200 | (15'($random(seed)) & 15'h00fe)});
    port(1, w);
    port(2, 16'h0000);
    check(data_rdata, 16'h0000);
    // programming session with a command dropped while busy
    issue(cw(OP_EXT, {EXT_EWEN, 4'h0}), 16'h0000);
    issue(cw(OP_WRITE, a), w);
    port(1, cw(OP_WRITE, d));
    port(0, {1'b0, REG_SI_STAT});
    port(2, 16'h0000);
    check(data_rdata[SI_BUSY_BIT], 1'b1);
    issue(cw(OP_ERASE, e), 16'h0000);
    wait_idle();
    check({u_ee.mem[a], u_ee.mem[d], u_ee.mem[e]},
          {w, 16'hffff, 16'hffff});
    issue(cw(OP_EXT, {EXT_ERAL, 4'h0}), 16'h0000);
    wait_idle();
    check(u_ee.mem[a], 16'hffff);
    slow = 1'b1;
    issue(cw(OP_EXT, {EXT_WRAL, 4'h0}), v);
    issue(cw(OP_EXT, {EXT_EWDS, 4'h0}), 16'h0000);
    issue(cw(OP_READ, a), 16'h0000);
    wait_idle();
    port(0, {1'b0, REG_EE_DATA});
    port(2, 16'h0000);
    check(data_rdata, v);
    check(u_ee.early, 0);
    // boot again from an image without the presence tag
    boot();
    check({cfg_present, io_base, station_addr},
          {1'b0, IO_BASE_DEF, 48'h0});
    end_of_test();
  end
endmodule : secp_eeprom_cfg_tb
`default_nettype wire
